// ---- hdl/scfg_pkg.sv ----
package scfg_pkg;

    // line modes as presented on the mode input
    typedef enum logic [1:0] {
        SCFG_MODE_T1   = 2'b00,
        SCFG_MODE_E1   = 2'b01,
        SCFG_MODE_CC   = 2'b10,
        SCFG_MODE_6312 = 2'b11
    } scfg_mode_t;

    // kind of reference carried by the transmit sync pin
    typedef enum logic [1:0] {
        SCFG_TS_FRAME = 2'b00,
        SCFG_TS_MF    = 2'b01,
        SCFG_TS_8K    = 2'b10,
        SCFG_TS_400   = 2'b11
    } scfg_ts_kind_t;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;

    localparam logic [7:0]  OFS_IO_CFG_ONE  = 8'h01;
    localparam logic [7:0]  OFS_IO_CFG_TWO  = 8'h02;

    localparam logic [7:0]  RST_IO_CFG_ONE  = 8'h00;
    localparam logic [7:0]  RST_IO_CFG_TWO  = 8'h00;
    localparam logic [7:0]  RST_RDATA       = 8'h00;

    // writable bits; reserved bits are not stored and read as zero
    localparam logic [7:0]  MASK_IO_CFG_ONE = 8'h7f;
    localparam logic [7:0]  MASK_IO_CFG_TWO = 8'hf0;

    // io_config_one fields
    localparam int          BIT_OUT_FMT     = 0;
    localparam int          BIT_TS_DIR      = 1;
    localparam int          BIT_TS_MF_SEL   = 2;
    localparam int          BIT_CC_REF_DW   = 3;
    localparam int          BIT_ALARM_SEL   = 4;
    localparam int          BIT_RS_MODE_A   = 5;
    localparam int          BIT_RS_MODE_B   = 6;

    // io_config_two fields
    localparam int          BIT_TS_INV      = 4;
    localparam int          BIT_RS_INV      = 5;
    localparam int          BIT_TX_LINE_CLOCK_INV    = 6;
    localparam int          BIT_RCLK_INV    = 7;

endpackage

// ---- hdl/scfg_pulse_widen.sv ----
`timescale 1ns/10ps
`default_nettype none

// stretches a sync pulse by one further bit period when asked to
module scfg_pulse_widen (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_bit_en,
    input  wire logic i_pulse,
    input  wire logic i_widen,
    output logic      o_pulse
);

    logic ext_q;
    logic ext_d;
    logic tail_q;
    logic tail_d;

    always_comb begin
        ext_d  = ext_q;
        tail_d = tail_q;
        if (i_bit_en) begin
            // remember a pulse to widen, then run its tail for the
            // whole bit period that follows it
            ext_d  = i_pulse && i_widen;
            tail_d = ext_q;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_q  <= 1'b0;
            tail_q <= 1'b0;
        end else if (i_ce) begin
            ext_q  <= ext_d;
            tail_q <= tail_d;
        end
    end

    // on the strobe itself the tail comes from ext_q, so no cycle is lost
    assign o_pulse = i_pulse || (i_bit_en ? ext_q : tail_q);

endmodule
`default_nettype wire

// ---- hdl/scfg_top.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// [R01] format bit 0 gives bipolar on both outputs; 1 gives NRZ, negative held 0
// [R02] transmit sync direction bit: 0 pin is input, 1 pin is output
// [R03] T1/E1: transmit sync mode bit selects frame (0) or multiframe (1)
// [R04] composite clock: reference bit selects 8kHz (0) or 400Hz (1) reference
// [R05] T1 with double-wide and direction set: sync two clocks in signaling frames
// [R06] T1/E1: alarm pin shows frame loss (0) or transmit clock loss (1)
// [R07] composite clock with alarm bit 0: alarm pin shows composite clock error
// [R08] T1/E1: receive sync mode a selects frame (0) or multiframe (1) pulse
// [R09] T1, mode a 0: mode b 1 widens receive sync in signaling frames
// [R10] E1, mode a 1: mode b selects CAS (0) or CRC4 (1) multiframe
// [R11] software writes zero to unused bits of both configuration registers
// [R12] config two bits 7,5,4 invert receive clock, rx sync, tx sync
// [R13] config two bit 6 inverts the transmit clock
// [R14] all fields reset to zero; new settings act at once
module scfg_top (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_ce,
    input  wire logic [scfg_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic [scfg_pkg::DATA_W-1:0] i_wdata,
    output logic      [scfg_pkg::DATA_W-1:0] o_rdata,
    input  wire logic [1:0]                 i_line_mode,
    input  wire logic                       i_tx_bit_en,
    input  wire logic                       i_rx_bit_en,
    input  wire logic                       i_tx_line_clock,
    input  wire logic                       i_rx_line_clock,
    output logic                            o_tx_line_clock,
    output logic                            o_rx_line_clock,
    input  wire logic                       i_tx_bip_pos,
    input  wire logic                       i_tx_bip_neg,
    input  wire logic                       i_tx_nrz,
    output logic                            o_tx_data_pos,
    output logic                            o_tx_data_neg,
    input  wire logic                       i_tx_frame_sync,
    input  wire logic                       i_tx_mf_sync,
    input  wire logic                       i_tx_sig_frame,
    input  wire logic                       i_cc_ref_8k,
    input  wire logic                       i_cc_ref_400,
    input  wire logic                       i_tx_sync_pin,
    output logic                            o_tx_sync_pin,
    output logic                            o_tx_sync_pin_oe_n,
    output logic                            o_tx_sync_in,
    output logic      [1:0]                 o_tx_sync_kind,
    input  wire logic                       i_rx_frame_pulse,
    input  wire logic                       i_rx_mf_pulse,
    input  wire logic                       i_rx_cas_mf,
    input  wire logic                       i_rx_crc4_mf,
    input  wire logic                       i_rx_sig_frame,
    output logic                            o_rx_sync_out,
    input  wire logic                       i_rx_frame_loss,
    input  wire logic                       i_tx_clock_loss,
    input  wire logic                       i_cc_error,
    output logic                            o_rx_alarm_pin
);

    logic [7:0] cfg1_q;
    logic [7:0] cfg1_d;
    logic [7:0] cfg2_q;
    logic [7:0] cfg2_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic       tx_line_clock_q;
    logic       tx_line_clock_d;
    logic       rclk_q;
    logic       rclk_d;
    logic       tx_data_pos_q;
    logic       tx_data_pos_d;
    logic       tx_data_neg_q;
    logic       tx_data_neg_d;
    logic       ts_out_q;
    logic       ts_out_d;
    logic       ts_oe_n_q;
    logic       ts_oe_n_d;
    logic       ts_in_q;
    logic       ts_in_d;
    logic [1:0] ts_kind_q;
    logic [1:0] ts_kind_d;
    logic       rs_q;
    logic       rs_d;
    logic       alarm_q;
    logic       alarm_d;

    logic       ts_pulse_raw;
    logic       ts_pulse_wide;
    logic       ts_widen;
    logic       rs_pulse_raw;
    logic       rs_pulse_wide;
    logic       rs_widen;

    scfg_pkg::scfg_mode_t mode;

    function automatic logic is_t1e1(input scfg_pkg::scfg_mode_t m);
        is_t1e1 = (m == scfg_pkg::SCFG_MODE_T1) ||
                  (m == scfg_pkg::SCFG_MODE_E1);
    endfunction

    assign mode = scfg_pkg::scfg_mode_t'(i_line_mode);

    // ---------------- register port ----------------
    always_comb begin
        cfg1_d  = cfg1_q;
        cfg2_d  = cfg2_q;
        rdata_d = rdata_q;
        if (i_wr) begin
            // unused bits are dropped so they always read back zero [R11]
            if (i_addr == scfg_pkg::OFS_IO_CFG_ONE) begin
                cfg1_d = i_wdata & scfg_pkg::MASK_IO_CFG_ONE;
            end
            if (i_addr == scfg_pkg::OFS_IO_CFG_TWO) begin
                cfg2_d = i_wdata & scfg_pkg::MASK_IO_CFG_TWO;
            end
        end
        if (i_rd) begin
            case (i_addr)
                scfg_pkg::OFS_IO_CFG_ONE: rdata_d = cfg1_q;
                scfg_pkg::OFS_IO_CFG_TWO: rdata_d = cfg2_q;
                default:                  rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg1_q  <= scfg_pkg::RST_IO_CFG_ONE; // [R14]
            cfg2_q  <= scfg_pkg::RST_IO_CFG_TWO; // [R14]
            rdata_q <= scfg_pkg::RST_RDATA;
        end else if (i_ce) begin
            cfg1_q  <= cfg1_d;
            cfg2_q  <= cfg2_d;
            rdata_q <= rdata_d;
        end
    end

    // ---------------- sync pulse stretchers ----------------
    assign ts_pulse_raw = cfg1_q[scfg_pkg::BIT_TS_MF_SEL] ?
                          i_tx_mf_sync : i_tx_frame_sync;
    assign ts_widen     = (mode == scfg_pkg::SCFG_MODE_T1) &&
                          cfg1_q[scfg_pkg::BIT_CC_REF_DW] &&
                          cfg1_q[scfg_pkg::BIT_TS_DIR] &&
                          i_tx_sig_frame; // [R05]

    scfg_pulse_widen u_ts_widen (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_bit_en  (i_tx_bit_en),
        .i_pulse   (ts_pulse_raw),
        .i_widen   (ts_widen),
        .o_pulse   (ts_pulse_wide)
    );

    assign rs_pulse_raw = i_rx_frame_pulse;
    assign rs_widen     = (mode == scfg_pkg::SCFG_MODE_T1) &&
                          !cfg1_q[scfg_pkg::BIT_RS_MODE_A] &&
                          cfg1_q[scfg_pkg::BIT_RS_MODE_B] &&
                          i_rx_sig_frame; // [R09]

    scfg_pulse_widen u_rs_widen (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_bit_en  (i_rx_bit_en),
        .i_pulse   (rs_pulse_raw),
        .i_widen   (rs_widen),
        .o_pulse   (rs_pulse_wide)
    );

    // ---------------- pin functions ----------------
    always_comb begin
        // clock polarity [R12] [R13]
        tx_line_clock_d = i_tx_line_clock ^ cfg2_q[scfg_pkg::BIT_TX_LINE_CLOCK_INV]; // [R13]
        rclk_d = i_rx_line_clock ^ cfg2_q[scfg_pkg::BIT_RCLK_INV]; // [R12]

        // line data format
        if (cfg1_q[scfg_pkg::BIT_OUT_FMT]) begin
            tx_data_pos_d = i_tx_nrz; // [R01]
            tx_data_neg_d = 1'b0;     // [R01]
        end else begin
            tx_data_pos_d = i_tx_bip_pos; // [R01]
            tx_data_neg_d = i_tx_bip_neg; // [R01]
        end

        // transmit sync pin: kind of reference, then direction
        case (mode)
            scfg_pkg::SCFG_MODE_T1, scfg_pkg::SCFG_MODE_E1: begin
                ts_kind_d = cfg1_q[scfg_pkg::BIT_TS_MF_SEL] ?
                            scfg_pkg::SCFG_TS_MF :
                            scfg_pkg::SCFG_TS_FRAME; // [R03]
                ts_out_d  = ts_pulse_wide;           // [R03] [R05]
            end
            scfg_pkg::SCFG_MODE_CC: begin
                ts_kind_d = cfg1_q[scfg_pkg::BIT_CC_REF_DW] ?
                            scfg_pkg::SCFG_TS_400 :
                            scfg_pkg::SCFG_TS_8K;    // [R04]
                ts_out_d  = cfg1_q[scfg_pkg::BIT_CC_REF_DW] ?
                            i_cc_ref_400 : i_cc_ref_8k; // [R04]
            end
            default: begin
                ts_kind_d = scfg_pkg::SCFG_TS_FRAME;
                ts_out_d  = i_tx_frame_sync;
            end
        endcase
        ts_out_d  = ts_out_d ^ cfg2_q[scfg_pkg::BIT_TS_INV]; // [R12]
        ts_oe_n_d = !cfg1_q[scfg_pkg::BIT_TS_DIR];           // [R02]
        // an input-mode pin is handed on with its polarity undone
        ts_in_d   = cfg1_q[scfg_pkg::BIT_TS_DIR] ? 1'b0 :
                    (i_tx_sync_pin ^ cfg2_q[scfg_pkg::BIT_TS_INV]); // [R02]

        // receive sync output
        case (mode)
            scfg_pkg::SCFG_MODE_T1: begin
                rs_d = cfg1_q[scfg_pkg::BIT_RS_MODE_A] ?
                       i_rx_mf_pulse : rs_pulse_wide; // [R08] [R09]
            end
            scfg_pkg::SCFG_MODE_E1: begin
                if (cfg1_q[scfg_pkg::BIT_RS_MODE_A]) begin
                    rs_d = cfg1_q[scfg_pkg::BIT_RS_MODE_B] ?
                           i_rx_crc4_mf : i_rx_cas_mf; // [R10]
                end else begin
                    rs_d = i_rx_frame_pulse; // [R08]
                end
            end
            default: begin
                rs_d = i_rx_frame_pulse;
            end
        endcase
        rs_d = rs_d ^ cfg2_q[scfg_pkg::BIT_RS_INV]; // [R12]

        // receive alarm pin
        case (mode)
            scfg_pkg::SCFG_MODE_T1, scfg_pkg::SCFG_MODE_E1: begin
                alarm_d = cfg1_q[scfg_pkg::BIT_ALARM_SEL] ?
                          i_tx_clock_loss : i_rx_frame_loss; // [R06]
            end
            scfg_pkg::SCFG_MODE_CC: begin
                // the select bit must stay 0 here; a 1 silences the pin
                alarm_d = !cfg1_q[scfg_pkg::BIT_ALARM_SEL] &&
                          i_cc_error; // [R07]
            end
            default: begin
                alarm_d = i_rx_frame_loss;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_line_clock_q    <= 1'b0;
            rclk_q    <= 1'b0;
            tx_data_pos_q    <= 1'b0;
            tx_data_neg_q    <= 1'b0;
            ts_out_q  <= 1'b0;
            ts_oe_n_q <= 1'b1;
            ts_in_q   <= 1'b0;
            ts_kind_q <= scfg_pkg::SCFG_TS_FRAME;
            rs_q      <= 1'b0;
            alarm_q   <= 1'b0;
        end else if (i_ce) begin
            tx_line_clock_q    <= tx_line_clock_d;
            rclk_q    <= rclk_d;
            tx_data_pos_q    <= tx_data_pos_d;
            tx_data_neg_q    <= tx_data_neg_d;
            ts_out_q  <= ts_out_d;
            ts_oe_n_q <= ts_oe_n_d;
            ts_in_q   <= ts_in_d;
            ts_kind_q <= ts_kind_d;
            rs_q      <= rs_d;
            alarm_q   <= alarm_d;
        end
    end

    assign o_rdata            = rdata_q;
    assign o_tx_line_clock    = tx_line_clock_q;
    assign o_rx_line_clock    = rclk_q;
    assign o_tx_data_pos      = tx_data_pos_q;
    assign o_tx_data_neg      = tx_data_neg_q;
    assign o_tx_sync_pin      = ts_out_q;
    assign o_tx_sync_pin_oe_n = ts_oe_n_q;
    assign o_tx_sync_in       = ts_in_q;
    assign o_tx_sync_kind     = ts_kind_q;
    assign o_rx_sync_out      = rs_q;
    assign o_rx_alarm_pin     = alarm_q;

    // ---------------- checks ----------------
    AST_NRZ_NEG_LOW: assert property ( // [R01]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && cfg1_q[scfg_pkg::BIT_OUT_FMT] |=> !o_tx_data_neg)
        else $error("negative data not held low in NRZ format");

    AST_NRZ_POS: assert property ( // [R01]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && cfg1_q[scfg_pkg::BIT_OUT_FMT] |=>
        o_tx_data_pos == $past(i_tx_nrz))
        else $error("positive data does not follow NRZ input");

    AST_BIPOLAR: assert property ( // [R01]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && !cfg1_q[scfg_pkg::BIT_OUT_FMT] |=>
        o_tx_data_pos == $past(i_tx_bip_pos) &&
        o_tx_data_neg == $past(i_tx_bip_neg))
        else $error("bipolar data not passed through");

    AST_TS_DIR: assert property ( // [R02]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce |=>
        o_tx_sync_pin_oe_n == !$past(cfg1_q[scfg_pkg::BIT_TS_DIR]))
        else $error("sync pin direction does not follow config");

    AST_TS_KIND: assert property ( // [R03]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && is_t1e1(mode) && cfg1_q[scfg_pkg::BIT_TS_MF_SEL] |=>
        o_tx_sync_kind == scfg_pkg::SCFG_TS_MF)
        else $error("multiframe sync not selected");

    AST_CC_400: assert property ( // [R04]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && mode == scfg_pkg::SCFG_MODE_CC &&
        cfg1_q[scfg_pkg::BIT_CC_REF_DW] |=>
        o_tx_sync_pin == ($past(i_cc_ref_400) ^
                          $past(cfg2_q[scfg_pkg::BIT_TS_INV])))
        else $error("400Hz reference not on sync pin");

    AST_TS_DOUBLE: assert property ( // [R05]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && i_tx_bit_en && ts_widen && ts_pulse_raw ##1
        !i_tx_bit_en [*3] ##1 (i_ce && i_tx_bit_en) ##1
        (i_ce && !i_tx_bit_en && mode == scfg_pkg::SCFG_MODE_T1 &&
         !cfg2_q[scfg_pkg::BIT_TS_INV]) |=> o_tx_sync_pin)
        else $error("sync pulse not stretched in signaling frame");

    AST_ALARM_TX_CLOCK_LOSS: assert property ( // [R06]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && is_t1e1(mode) && cfg1_q[scfg_pkg::BIT_ALARM_SEL] |=>
        o_rx_alarm_pin == $past(i_tx_clock_loss))
        else $error("alarm pin not showing transmit clock loss");

    AST_ALARM_CC: assert property ( // [R07]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && mode == scfg_pkg::SCFG_MODE_CC &&
        !cfg1_q[scfg_pkg::BIT_ALARM_SEL] |=>
        o_rx_alarm_pin == $past(i_cc_error))
        else $error("alarm pin not showing composite clock error");

    AST_RS_CRC4: assert property ( // [R10]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && mode == scfg_pkg::SCFG_MODE_E1 &&
        cfg1_q[scfg_pkg::BIT_RS_MODE_A] &&
        cfg1_q[scfg_pkg::BIT_RS_MODE_B] |=>
        o_rx_sync_out == ($past(i_rx_crc4_mf) ^
                          $past(cfg2_q[scfg_pkg::BIT_RS_INV])))
        else $error("receive sync not on CRC4 multiframe");

    AST_RCLK_INV: assert property ( // [R12]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce |=> o_rx_line_clock ==
        ($past(i_rx_line_clock) ^ $past(cfg2_q[scfg_pkg::BIT_RCLK_INV])))
        else $error("receive clock polarity wrong");

    AST_TX_LINE_CLOCK_INV: assert property ( // [R13]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce |=> o_tx_line_clock ==
        ($past(i_tx_line_clock) ^ $past(cfg2_q[scfg_pkg::BIT_TX_LINE_CLOCK_INV])))
        else $error("transmit clock polarity wrong");

    AST_WRITE_NOW: assert property ( // [R14]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == scfg_pkg::OFS_IO_CFG_TWO |=>
        cfg2_q == ($past(i_wdata) & scfg_pkg::MASK_IO_CFG_TWO))
        else $error("config two write not taken at once");

endmodule
`default_nettype wire

// ---- sim/scfg_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none

// external sync equipment sharing the transmit sync wire with the device
module scfg_far_end (
    input  wire logic i_dev_drive,
    input  wire logic i_dev_oe_n,
    input  wire logic i_ext_level,
    output logic      o_wire
);
    // the far side drives only while the device has released the pin
    assign o_wire = i_dev_oe_n ? i_ext_level : i_dev_drive;
endmodule

`default_nettype wire

// ---- sim/tb_scfg_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_scfg_top;
    typedef struct {int due; logic [18:0] msk; logic [18:0] val;} scfg_note_t;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [1:0]  mode;
    logic [20:0] stim;
    wire logic   tx_ben, rx_ben, txc, rxc, bpos, bneg, nrz, fsync, mfsync;
    wire logic   tsig, r8k, r400, ext_lvl, rfp, rmf, rcas, rcrc, rsig;
    wire logic   rfl, tcl, cce;
    logic        pin_wire;
    logic [7:0]  rdata;
    logic        o_txc, o_rxc, dpos, dneg, spin, soe_n, sin, rso, alm;
    logic [1:0]  kind;
    logic [18:0] obs;
    scfg_note_t  notes[$];
    int          cyc;
    int          errors;
    int          samples_checked;
    integer      seed;

    assign {tx_ben, rx_ben, txc, rxc, bpos, bneg, nrz, fsync, mfsync, tsig,
            r8k, r400, ext_lvl, rfp, rmf, rcas, rcrc, rsig, rfl, tcl,
            cce} = stim;
    assign obs = {rdata, o_txc, o_rxc, dpos, dneg, spin, soe_n, sin, kind,
                  rso, alm};

    scfg_top i_scfg_top (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
        .i_line_mode(mode), .i_tx_bit_en(tx_ben), .i_rx_bit_en(rx_ben),
        .i_tx_line_clock(txc), .i_rx_line_clock(rxc),
        .o_tx_line_clock(o_txc), .o_rx_line_clock(o_rxc),
        .i_tx_bip_pos(bpos), .i_tx_bip_neg(bneg), .i_tx_nrz(nrz),
        .o_tx_data_pos(dpos), .o_tx_data_neg(dneg),
        .i_tx_frame_sync(fsync), .i_tx_mf_sync(mfsync),
        .i_tx_sig_frame(tsig), .i_cc_ref_8k(r8k), .i_cc_ref_400(r400),
        .i_tx_sync_pin(pin_wire), .o_tx_sync_pin(spin),
        .o_tx_sync_pin_oe_n(soe_n), .o_tx_sync_in(sin),
        .o_tx_sync_kind(kind), .i_rx_frame_pulse(rfp), .i_rx_mf_pulse(rmf),
        .i_rx_cas_mf(rcas), .i_rx_crc4_mf(rcrc), .i_rx_sig_frame(rsig),
        .o_rx_sync_out(rso), .i_rx_frame_loss(rfl),
        .i_tx_clock_loss(tcl), .i_cc_error(cce), .o_rx_alarm_pin(alm)
    );

    scfg_far_end i_scfg_far_end (
        .i_dev_drive(spin), .i_dev_oe_n(soe_n), .i_ext_level(ext_lvl),
        .o_wire(pin_wire)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic note(input logic [18:0] m, input logic [18:0] v);
        scfg_note_t n;
        n.due = cyc + 2;
        n.msk = m;
        n.val = v & m;
        notes.push_back(n);
    endtask

    // results appear two falling edges after the inputs were launched
    initial begin
        cyc = 0;
        forever begin
            @(negedge clk);
            cyc++;
            while (notes.size() > 0 && notes[0].due <= cyc) begin
                check(obs & notes[0].msk, notes[0].val);
                void'(notes.pop_front());
            end
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        note(19'h7f800, {e, 11'h000});
        @(posedge clk);
        rd <= 1'b0;
    endtask

    function automatic logic [18:0] ref_out(input logic [7:0] c1,
            input logic [7:0] c2, input logic [1:0] md,
            input logic [20:0] s);
        logic [1:0] k;
        logic       src;
        logic       rs;
        logic       al;
        logic       t1e1;
        t1e1 = (md == scfg_pkg::SCFG_MODE_T1) || (md == scfg_pkg::SCFG_MODE_E1);
        if (t1e1)
            k = c1[2] ? 2'h1 : 2'h0;
        else if (md == scfg_pkg::SCFG_MODE_CC)
            k = c1[3] ? 2'h3 : 2'h2;
        else
            k = 2'h0;
        src = (k == 2'h0) ? s[13] : (k == 2'h1) ? s[12] :
              (k == 2'h2) ? s[10] : s[9];
        if (!t1e1 || !c1[5])
            rs = s[7];
        else if (md == scfg_pkg::SCFG_MODE_T1)
            rs = s[6];
        else
            rs = c1[6] ? s[4] : s[5];
        if (t1e1)
            al = c1[4] ? s[1] : s[2];
        else
            al = (md == scfg_pkg::SCFG_MODE_CC) ? s[0] : s[2];
        return {8'h00, s[18] ^ c2[6], s[17] ^ c2[7],
                c1[0] ? s[14] : s[16], c1[0] ? 1'b0 : s[15],
                src ^ c2[4], ~c1[1], c1[1] ? 1'b0 : s[8] ^ c2[4],
                k, rs ^ c2[5], al};
    endfunction

    task automatic stretch(input logic sig);
        logic [20:0] s;
        logic [18:0] e;
        for (int k = 0; k < 12; k++) begin
            s = '0;
            s[20] = (k % 4 == 0);
            s[19] = (k % 4 == 0);
            s[13] = (k < 4);
            s[7] = (k < 4);
            s[11] = sig;
            s[3] = sig;
            @(posedge clk);
            stim <= s;
            e = (k < 4 || (sig && k < 8)) ? 19'h00042 : 19'h00000;
            note(19'h00042, e);
        end
    endtask

    task automatic report_and_stop();
        $display("checked=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(40 * 10000);
        errors++;
        report_and_stop();
    end

    initial begin
        logic [7:0]  c1;
        logic [7:0]  c2;
        logic [1:0]  md;
        logic [20:0] s;
        logic [18:0] msk;
        logic [18:0] exp;
        logic [18:0] last;
        logic        cen;
        seed = 32'h862f;
        errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        mode = 2'h0;
        stim = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(obs, 19'h00020);
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(scfg_pkg::OFS_IO_CFG_ONE, 8'h00);
        reg_rd(scfg_pkg::OFS_IO_CFG_TWO, 8'h00);
        reg_wr(8'h05, 8'h5a);
        reg_rd(8'h05, 8'h00);
        $display("test reset and map done");
        for (int i = 0; i < 40; i++) begin
            md = 2'($random(seed));
            c1 = 8'($random(seed)) & 8'h7f;
            c2 = 8'($random(seed)) & 8'hf0;
            if (md[1])
                c1[2] = 1'b0;
            if (md[0])
                c1[3] = 1'b0;
            if (md[1])
                c1[4] = 1'b0;
            @(posedge clk);
            mode <= md;
            ce <= 1'b1;
            reg_wr(scfg_pkg::OFS_IO_CFG_ONE, c1);
            reg_wr(scfg_pkg::OFS_IO_CFG_TWO, c2);
            reg_rd(scfg_pkg::OFS_IO_CFG_ONE, c1);
            reg_rd(scfg_pkg::OFS_IO_CFG_TWO, c2);
            msk = 19'h007ff;
            last = '0;
            for (int j = 0; j < 8; j++) begin
                s = 21'($random(seed));
                s[11] = 1'b0;
                s[3] = 1'b0;
                cen = (j == 0) || ($random(seed) % 4 != 0);
                // a frozen cycle keeps the previous outputs
                exp = cen ? ref_out(c1, c2, md, s) : last;
                last = exp;
                @(posedge clk);
                stim <= s;
                ce <= cen;
                note(msk, exp);
            end
        end
        $display("test random pin functions done");
        @(posedge clk);
        ce <= 1'b1;
        mode <= scfg_pkg::SCFG_MODE_T1;
        reg_wr(scfg_pkg::OFS_IO_CFG_ONE, 8'h4a);
        reg_wr(scfg_pkg::OFS_IO_CFG_TWO, 8'h00);
        stretch(1'b1);
        stretch(1'b0);
        repeat (3) @(posedge clk);
        $display("test double wide sync done");
        report_and_stop();
    end
endmodule

`default_nettype wire
